// [bmpm_top.sv]
// Purpose: Power-mode sequencer of a battery monitor with AXI4-Lite registers
// Assumes: Measurements arrive on core_clk_i; bus lines and sleep oscillator are async pins
// Notes: Sleep oscillator is sampled, not used as a clock
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`include "bmpm_defines.svh"

// Overview of operation
// - Sample enable set, pack above power-on level, no sleep: periodic sampling
// - Sample enable cleared: back to continuous conversion
// - Sampling starts a conversion set every 0.5 s times two to the divider
// - Sample-sleep: analog off, sleep timed by sleep oscillator, one set per wake
// - Enabled cell below cell trip level enters sample-sleep
// - Cell trip blocked while charge wake enabled and current above charge level
// - Host sample-sleep request bit enters sample-sleep
// - Enabled low-current trip below discharge level enters sample-sleep
// - Sleep interval is 0.5 s times two to both dividers
// - Clearing the sample-sleep request returns to continuous conversion
// - Charge wake: current above charge level wakes to continuous conversion
// - Pack wake: pack above pack wake level wakes to continuous conversion
// - Shelf-sleep: no measurement, no accumulation, bus ignored, registers lost
// - Shelf armed by bit or low pack; entered after both lines low long enough
// - Both lines high long enough wake shelf-sleep to continuous conversion
// - After reset, continuous conversion once pack exceeds power-on level
// - Enabled accumulators add the current result every 500 ms
module bmpm_top
  import bmpm_pkg::*;
#(
  parameter int HALF_SEC_CYC = `BMPM_CLK_HZ / 1000 * `BMPM_HALF_SEC_MS,
  parameter int SLEEP_HALF_TICKS = `BMPM_SLEEP_OSC_HZ * `BMPM_HALF_SEC_MS / 1000,
  parameter int SHELF_ENTRY_TICKS = `BMPM_SHELF_ENTRY_TICKS,
  parameter int WAKE_TICKS = `BMPM_WAKE_TICKS,
  parameter logic [15:0] POR_LEVEL = `BMPM_POR_LEVEL
)(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Measurement results
  input wire logic [15:0] cell1_input_i,
  input wire logic [15:0] cell2_input_i,
  input wire logic [15:0] pack_voltage_i,
  input wire logic [15:0] current_i,
  input wire logic conv_done_i,
  // Pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sleep_osc_i,
  // Converter and system control
  output logic conv_run_o,
  output logic conv_start_o,
  output logic analog_on_o,
  output logic bus_enable_o,
  output logic [4:0] mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  bmpm_state_type state_ff, nxt_state;
  logic [4:0] mode_ff;
  logic [3:0] adc_ff;
  logic [5:0] trip_ff;
  logic [15:0] thr_ff [`BMPM_NUM_THR];
  logic [31:0] chg_acc_ff, dis_acc_ff;
  logic analog_on_ff, conv_run_ff, conv_start_ff, bus_en_ff;

  // Three-stage pin synchronisers with agreement filter
  logic [2:0] pin_raw, s1_ff, s2_ff, s3_ff, pin_ff;
  assign pin_raw = {sleep_osc_i, sda_i, scl_i};
  for (genvar g = 0; g < 3; g++)
  begin : g_sync
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        s1_ff[g] <= 1'b0;
        s2_ff[g] <= 1'b0;
        s3_ff[g] <= 1'b0;
        pin_ff[g] <= 1'b0;
      end
      else
      begin
        s1_ff[g] <= pin_raw[g];
        s2_ff[g] <= s1_ff[g];
        s3_ff[g] <= s2_ff[g];
        if (s2_ff[g] == s3_ff[g])
          pin_ff[g] <= s3_ff[g];
      end
    end
  end

  logic osc_q_ff, sl_tick, both_low, both_high;
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
      osc_q_ff <= 1'b0;
    else
      osc_q_ff <= pin_ff[2];
  assign sl_tick = pin_ff[2] & ~osc_q_ff;
  assign both_low = ~pin_ff[0] & ~pin_ff[1];
  assign both_high = pin_ff[0] & pin_ff[1];

  // Half-second tick on the main clock
  logic [31:0] hs_cnt_ff;
  logic hs_tick_ff;
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hs_cnt_ff <= 32'h0;
      hs_tick_ff <= 1'b0;
    end
    else
    begin
      hs_tick_ff <= (hs_cnt_ff == 32'(HALF_SEC_CYC - 1));
      hs_cnt_ff <= (hs_cnt_ff == 32'(HALF_SEC_CYC - 1)) ? 32'h0 : hs_cnt_ff + 32'h1;
    end
  end

  // Trip and wake comparisons
  logic req, samp_en, pack_ok, shelf_armed, cell_trip, chg_over, lc_trip, sleep_go, wake_go;
  assign req = mode_ff[`BMPM_MODE_REQ];
  assign samp_en = adc_ff[`BMPM_ADC_SAMP];
  assign pack_ok = pack_voltage_i > POR_LEVEL;
  assign shelf_armed = mode_ff[`BMPM_MODE_SHELF] |
                       (pack_voltage_i < thr_ff[`BMPM_THR_SHELF]);
  assign cell_trip = (trip_ff[`BMPM_TRIP_C1] & (cell1_input_i < thr_ff[`BMPM_THR_CELL])) |
                     (trip_ff[`BMPM_TRIP_C2] & (cell2_input_i < thr_ff[`BMPM_THR_CELL]));
  assign chg_over = trip_ff[`BMPM_TRIP_CW] &
                    ($signed(current_i) > $signed(thr_ff[`BMPM_THR_CHG]));
  assign lc_trip = trip_ff[`BMPM_TRIP_LC] &
                   ($signed(current_i) < $signed(thr_ff[`BMPM_THR_DIS]));
  assign sleep_go = (cell_trip & ~chg_over) | req | lc_trip;
  assign wake_go = chg_over |
                   (trip_ff[`BMPM_TRIP_PW] & (pack_voltage_i > thr_ff[`BMPM_THR_PWAKE]));

  // Shelf entry and wake timers on sleep oscillator ticks
  logic [31:0] low_cnt_ff, high_cnt_ff;
  logic shelf_go, wake_done;
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      low_cnt_ff <= 32'h0;
    else if (!(shelf_armed && both_low) || state_ff == BMPM_SHELF || state_ff == BMPM_POR)
      low_cnt_ff <= 32'h0;
    else if (sl_tick && low_cnt_ff != 32'(SHELF_ENTRY_TICKS))
      low_cnt_ff <= low_cnt_ff + 32'h1;
  end
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      high_cnt_ff <= 32'h0;
    else if (!both_high || state_ff != BMPM_SHELF)
      high_cnt_ff <= 32'h0;
    else if (sl_tick && high_cnt_ff != 32'(WAKE_TICKS))
      high_cnt_ff <= high_cnt_ff + 32'h1;
  end
  assign shelf_go = shelf_armed & both_low & (low_cnt_ff == 32'(SHELF_ENTRY_TICKS));
  assign wake_done = both_high & (high_cnt_ff == 32'(WAKE_TICKS));

  logic req_q_ff, req_fell;
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
      req_q_ff <= 1'b0;
    else
      req_q_ff <= req;
  assign req_fell = req_q_ff & ~req;

  // Mode sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      BMPM_POR:
        if (pack_ok)
          nxt_state = BMPM_RUN;
      BMPM_SHELF:
        if (wake_done)
          nxt_state = BMPM_RUN;
      BMPM_RUN, BMPM_SAMP:
        if (!pack_ok)
          nxt_state = BMPM_POR;
        else if (shelf_go)
          nxt_state = BMPM_SHELF;
        else if (sleep_go)
          nxt_state = BMPM_SAMP_SLEEP;
        else if (samp_en)
          nxt_state = BMPM_SAMP;
        else
          nxt_state = BMPM_RUN;
      BMPM_SAMP_SLEEP:
        if (!pack_ok)
          nxt_state = BMPM_POR;
        else if (shelf_go)
          nxt_state = BMPM_SHELF;
        else if (wake_go || req_fell)
          nxt_state = BMPM_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff <= BMPM_POR;
      conv_run_ff <= 1'b0;
      bus_en_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      conv_run_ff <= (nxt_state == BMPM_RUN);
      bus_en_ff <= (nxt_state != BMPM_SHELF) && (nxt_state != BMPM_POR);
    end
  end

  // Sampling and sleep interval timers
  logic [7:0] samp_cnt_ff, samp_lim;
  logic [31:0] sl_cnt_ff, sl_lim;
  logic samp_fire, sl_fire;
  assign samp_lim = (8'h01 << adc_ff[3:1]) - 8'h01;
  assign sl_lim = 32'(SLEEP_HALF_TICKS) << ({1'b0, adc_ff[3:1]} + {1'b0, mode_ff[3:1]});
  assign samp_fire = (state_ff == BMPM_SAMP) && hs_tick_ff && (samp_cnt_ff == samp_lim);
  assign sl_fire = (state_ff == BMPM_SAMP_SLEEP) && !analog_on_ff && sl_tick &&
                   (sl_cnt_ff == sl_lim - 32'h1);
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      samp_cnt_ff <= 8'h00;
    else if (state_ff != BMPM_SAMP)
      samp_cnt_ff <= 8'h00;
    else if (hs_tick_ff)
      samp_cnt_ff <= samp_fire ? 8'h00 : samp_cnt_ff + 8'h01;
  end
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sl_cnt_ff <= 32'h0;
    else if (state_ff != BMPM_SAMP_SLEEP || analog_on_ff)
      sl_cnt_ff <= 32'h0;
    else if (sl_tick)
      sl_cnt_ff <= sl_fire ? 32'h0 : sl_cnt_ff + 32'h1;
  end
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      conv_start_ff <= 1'b0;
      analog_on_ff <= 1'b0;
    end
    else
    begin
      conv_start_ff <= samp_fire | sl_fire;
      if (nxt_state == BMPM_RUN || nxt_state == BMPM_SAMP)
        analog_on_ff <= 1'b1;
      else if (nxt_state != BMPM_SAMP_SLEEP || state_ff != BMPM_SAMP_SLEEP)
        analog_on_ff <= 1'b0;
      else if (sl_fire)
        analog_on_ff <= 1'b1;
      else if (conv_done_i)
        analog_on_ff <= 1'b0;
    end
  end

  // Charge and discharge accumulators
  logic [16:0] dis_mag;
  assign dis_mag = 17'h00000 - {current_i[15], current_i};
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      chg_acc_ff <= 32'h0;
      dis_acc_ff <= 32'h0;
    end
    else if (state_ff == BMPM_SHELF)
    begin
      chg_acc_ff <= 32'h0;
      dis_acc_ff <= 32'h0;
    end
    else if (state_ff != BMPM_POR && hs_tick_ff && trip_ff[`BMPM_TRIP_ACC])
    begin
      if (!current_i[15])
        chg_acc_ff <= chg_acc_ff + {16'h0000, current_i};
      else
        dis_acc_ff <= dis_acc_ff + {15'h0000, dis_mag};
    end
  end

  // AXI4-Lite slave
  logic aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff, wmask, wr_val;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic aw_take, w_take, ar_take, wr_do, nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
  assign aw_take = s_axi_awvalid_i & awready_ff;
  assign w_take = s_axi_wvalid_i & wready_ff;
  assign ar_take = s_axi_arvalid_i & arready_ff;
  assign wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign nxt_aw_got = aw_take | (aw_got_ff & ~wr_do);
  assign nxt_w_got = w_take | (w_got_ff & ~wr_do);
  assign nxt_bvalid = wr_do | (bvalid_ff & ~s_axi_bready_i);
  assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready_i);

  function automatic logic mapped(input logic [7:0] a);
    return a[7:2] <= `BMPM_OFS_DACC >> 2;
  endfunction
  function automatic logic [31:0] rd_val(input logic [7:0] a);
    logic [7:0] w;
    logic [31:0] v;
    w = {a[7:2], 2'b00};
    v = 32'h0;
    if (w == `BMPM_OFS_MODE)
      v = {27'h0, mode_ff};
    else if (w == `BMPM_OFS_ADC)
      v = {28'h0, adc_ff};
    else if (w == `BMPM_OFS_TRIP)
      v = {26'h0, trip_ff};
    else if (w >= `BMPM_OFS_THR0 && w < `BMPM_OFS_STAT)
      v = {16'h0000, thr_ff[3'(a[7:2] - (`BMPM_OFS_THR0 >> 2))]};
    else if (w == `BMPM_OFS_STAT)
      v = {25'h0, shelf_armed, analog_on_ff, state_ff};
    else if (w == `BMPM_OFS_CACC)
      v = chg_acc_ff;
    else if (w == `BMPM_OFS_DACC)
      v = dis_acc_ff;
    return v;
  endfunction

  assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  always_comb
  begin
    wr_val = (rd_val(aw_addr_ff) & ~wmask) | (w_data_ff & wmask);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `BMPM_RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
      if (aw_take)
        aw_addr_ff <= s_axi_awaddr_i;
      if (w_take)
      begin
        w_data_ff <= s_axi_wdata_i;
        w_strb_ff <= s_axi_wstrb_i;
      end
      bvalid_ff <= nxt_bvalid;
      if (wr_do)
        bresp_ff <= mapped(aw_addr_ff) ? `BMPM_RESP_OKAY : `BMPM_RESP_SLVERR;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `BMPM_RESP_OKAY;
    end
    else
    begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= rd_val(s_axi_araddr_i);
        rresp_ff <= mapped(s_axi_araddr_i) ? `BMPM_RESP_OKAY : `BMPM_RESP_SLVERR;
      end
    end
  end

  // Control registers; shelf-sleep drops them to reset values
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_ff <= `BMPM_RST_MODE;
      adc_ff <= `BMPM_RST_ADC;
      trip_ff <= `BMPM_RST_TRIP;
      for (int i = 0; i < `BMPM_NUM_THR; i++)
        thr_ff[i] <= `BMPM_RST_THR;
    end
    // Cleared on the entry edge too, so no shelf cycle still shows old contents
    else if (state_ff == BMPM_SHELF || nxt_state == BMPM_SHELF)
    begin
      mode_ff <= `BMPM_RST_MODE;
      adc_ff <= `BMPM_RST_ADC;
      trip_ff <= `BMPM_RST_TRIP;
      for (int i = 0; i < `BMPM_NUM_THR; i++)
        thr_ff[i] <= `BMPM_RST_THR;
    end
    else if (wr_do)
    begin
      if ({aw_addr_ff[7:2], 2'b00} == `BMPM_OFS_MODE)
        mode_ff <= wr_val[4:0];
      else if ({aw_addr_ff[7:2], 2'b00} == `BMPM_OFS_ADC)
        adc_ff <= wr_val[3:0];
      else if ({aw_addr_ff[7:2], 2'b00} == `BMPM_OFS_TRIP)
        trip_ff <= wr_val[5:0];
      else if ({aw_addr_ff[7:2], 2'b00} >= `BMPM_OFS_THR0 &&
               {aw_addr_ff[7:2], 2'b00} < `BMPM_OFS_STAT)
        thr_ff[3'(aw_addr_ff[7:2] - (`BMPM_OFS_THR0 >> 2))] <= wr_val[15:0];
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign conv_run_o = conv_run_ff;
  assign conv_start_o = conv_start_ff;
  assign analog_on_o = analog_on_ff;
  assign bus_enable_o = bus_en_ff;
  assign mode_o = state_ff;

  a_samp_enter: assert property (state_ff == BMPM_RUN && pack_ok && !shelf_go && !sleep_go &&
    samp_en |=> state_ff == BMPM_SAMP && !conv_run_o) else $error("sampling not entered");
  a_samp_leave: assert property (state_ff == BMPM_SAMP && pack_ok && !shelf_go && !sleep_go &&
    !samp_en |=> state_ff == BMPM_RUN && conv_run_o) else $error("sampling not left");
  a_samp_start: assert property (samp_fire |=> conv_start_o ##1 !conv_start_o)
    else $error("sample start missing");
  a_sleep_dark: assert property (state_ff == BMPM_SAMP_SLEEP && nxt_state == BMPM_SAMP_SLEEP &&
    !sl_fire && conv_done_i |=> !analog_on_o) else $error("analog left on");
  a_cell_block: assert property (state_ff == BMPM_RUN && pack_ok && !shelf_go && cell_trip &&
    chg_over && !req && !lc_trip |=> state_ff != BMPM_SAMP_SLEEP)
    else $error("cell trip not blocked");
  a_sleep_enter: assert property (state_ff == BMPM_RUN && pack_ok && !shelf_go &&
    (req || lc_trip || (cell_trip && !chg_over)) |=> state_ff == BMPM_SAMP_SLEEP)
    else $error("sample-sleep not entered");
  a_sleep_wake: assert property (state_ff == BMPM_SAMP_SLEEP && pack_ok && !shelf_go &&
    (wake_go || $fell(req)) |=> state_ff == BMPM_RUN) else $error("no wake");
  a_shelf_quiet: assert property (state_ff == BMPM_SHELF |-> !bus_enable_o && !analog_on_o &&
    mode_ff == `BMPM_RST_MODE) else $error("shelf not quiet");
  a_shelf_enter: assert property (state_ff == BMPM_RUN && pack_ok && shelf_go |=>
    state_ff == BMPM_SHELF ##1 !bus_enable_o) else $error("shelf not entered");
  a_shelf_wake: assert property (state_ff == BMPM_SHELF && wake_done |=> state_ff == BMPM_RUN)
    else $error("shelf wake lost");
  a_por_run: assert property (state_ff == BMPM_POR && pack_ok |=> state_ff == BMPM_RUN ##1
    bus_enable_o) else $error("no run after reset");
  a_acc_add: assert property ((state_ff == BMPM_RUN || state_ff == BMPM_SAMP) && hs_tick_ff &&
    trip_ff[`BMPM_TRIP_ACC] && !current_i[15] |=>
    chg_acc_ff == $past(chg_acc_ff) + {16'h0000, $past(current_i)})
    else $error("accumulate wrong");
  c_samp_run: cover property (state_ff == BMPM_SAMP ##1 conv_start_o);
  c_sleep_set: cover property (sl_fire ##1 analog_on_o);
  c_shelf_cycle: cover property (state_ff == BMPM_SHELF ##1 state_ff == BMPM_RUN);
endmodule

// [bmpm_defines.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the power sequencer
// Assumes: 32-bit AXI4-Lite register words, 8-bit byte address
// Notes: Included by bmpm_top only
`ifndef BMPM_DEFINES_SVH
`define BMPM_DEFINES_SVH
`define BMPM_OFS_MODE 8'h00
`define BMPM_OFS_ADC 8'h04
`define BMPM_OFS_TRIP 8'h08
`define BMPM_OFS_THR0 8'h0C
`define BMPM_OFS_STAT 8'h20
`define BMPM_OFS_CACC 8'h24
`define BMPM_OFS_DACC 8'h28
`define BMPM_NUM_THR 5
`define BMPM_MODE_REQ 0
`define BMPM_MODE_SDIV 1
`define BMPM_MODE_SHELF 4
`define BMPM_ADC_SAMP 0
`define BMPM_ADC_DIV 1
`define BMPM_TRIP_C1 0
`define BMPM_TRIP_C2 1
`define BMPM_TRIP_LC 2
`define BMPM_TRIP_CW 3
`define BMPM_TRIP_PW 4
`define BMPM_TRIP_ACC 5
`define BMPM_THR_CELL 0
`define BMPM_THR_PWAKE 1
`define BMPM_THR_SHELF 2
`define BMPM_THR_CHG 3
`define BMPM_THR_DIS 4
`define BMPM_RST_MODE 5'h00
`define BMPM_RST_ADC 4'h0
`define BMPM_RST_TRIP 6'h00
`define BMPM_RST_THR 16'h0000
`define BMPM_POR_LEVEL 16'h0A00
`define BMPM_CLK_HZ 50000000
`define BMPM_HALF_SEC_MS 500
`define BMPM_SLEEP_OSC_HZ 32768
`define BMPM_SHELF_ENTRY_TICKS 32768
`define BMPM_WAKE_TICKS 64
`define BMPM_RESP_OKAY 2'h0
`define BMPM_RESP_SLVERR 2'h2
`endif

// [bmpm_pkg.sv]
// Purpose: Types of the power sequencer
// Assumes: One-hot state codes
// Notes: Constants live in bmpm_defines.svh
package bmpm_pkg;
  typedef enum logic [4:0] {
    BMPM_POR = 5'h01,
    BMPM_RUN = 5'h02,
    BMPM_SAMP = 5'h04,
    BMPM_SAMP_SLEEP = 5'h08,
    BMPM_SHELF = 5'h10
  } bmpm_state_type;
endpackage

// [bmpm_host_model.sv]
// Purpose: Host side of the two-wire bus, parking or releasing both lines
// Assumes: Both lines are pulled up, so a released line reads high
// Notes: park_i from the bench holds both lines low
module bmpm_host_model (
  // Control
  input wire logic park_i,
  // Bus lines
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign scl_o = ~park_i;
  assign sda_o = ~park_i;
endmodule

// [bmpm_bench.sv]
// Purpose: Self-checking bench of the power sequencer
// Assumes: Short timing parameters; sleep oscillator period is 8 core clocks
// Notes: Bus answers are compared against a queue of expected values
module bmpm_bench import bmpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 20;
  logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic cdone = 1'b0, park = 1'b0, osc = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [15:0] c1 = 16'h1000, c2 = 16'h1000, pk = 16'h0000, cur = 16'h0000;
  logic awr, wrd, bv, arr, rv, run, start, analog, busen, scl, sda;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] mode;
  logic [33:0] exp_q[$];
  logic [15:0] thr[5] = '{16'h0800, 16'h2000, 16'h0100, 16'h0100, 16'hFF00};
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic [31:0] v;

  bmpm_top #(.HALF_SEC_CYC(HALF), .SLEEP_HALF_TICKS(2), .SHELF_ENTRY_TICKS(4), .WAKE_TICKS(3))
  uut (
    .core_clk_i(clk), .resetn_i(rstn),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .cell1_input_i(c1), .cell2_input_i(c2), .pack_voltage_i(pk), .current_i(cur),
    .conv_done_i(cdone), .scl_i(scl), .sda_i(sda), .sleep_osc_i(osc),
    .conv_run_o(run), .conv_start_o(start), .analog_on_o(analog), .bus_enable_o(busen),
    .mode_o(mode)
  );
  bmpm_host_model host (.park_i(park), .scl_o(scl), .sda_o(sda));

  initial
  begin
    forever #10 clk = ~clk;
  end

  // Sleep oscillator, converter answer and run limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) osc <= ~osc;
    cdone <= start;
    if (cyc == 60000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  always @(posedge clk)
  begin
    if (bv === 1'b1 && bre) chk("bresp", {bresp, 32'h0}, exp_q.pop_front());
    if (rv === 1'b1 && rre) chk("rdata", {rresp, rdata}, exp_q.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, 32'h0});
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    bre <= 1'b0;
  endtask

  // Settles pending input changes before the address goes out
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    repeat (3) @(posedge clk);
    arv <= 1'b1;
    araddr <= a;
    rre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    rre <= 1'b0;
  endtask

  task automatic rs(input logic [7:0] a, input logic [31:0] d);
    rd(a, {2'h0, d});
  endtask

  task automatic gap(output int k);
    k = 0;
    do @(posedge clk); while (start !== 1'b1);
    do
    begin
      @(posedge clk);
      k++;
    end while (start !== 1'b1 && k < 5000);
  endtask

  task automatic wait_mode(input bmpm_state_type m, output int k);
    k = 0;
    while (mode !== m && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h5125BE82));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 3; i++) rs(8'(4 * i), 32'h0);
    rs(8'h20, 32'h01);
    pk <= 16'h1000;
    rs(8'h20, 32'h22);
    for (int i = 0; i < 5; i++)
    begin
      v = $urandom;
      wr(8'(12 + 4 * i), v);
      rs(8'(12 + 4 * i), v & 32'hFFFF);
      wr(8'(12 + 4 * i), {16'h0, thr[i]});
    end
    wr(8'h2C, 32'h5, 2'h2);
    rd(8'h2C, {2'h2, 32'h0});
    wr(8'h20, 32'h1F);
    rs(8'h20, 32'h22);
    for (int d = 0; d < 8; d++)
    begin
      wr(8'h04, {28'h0, 3'(d), 1'b1});
      rs(8'h20, 32'h24);
      gap(n);
      gap(n);
      chk("interval", 34'(n), 34'(HALF << d));
    end
    wr(8'h04, 32'h0);
    rs(8'h20, 32'h22);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h3);
    rs(8'h20, 32'h08);
    gap(n);
    chk("sleep", 34'(n > 24 && n < 50), 34'h1);
    chk("awake", 34'(analog), 34'h1);
    repeat (3) @(posedge clk);
    chk("analog", 34'(analog), 34'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
    rs(8'h20, 32'h22);
    for (int i = 0; i < 2; i++)
    begin
      cur <= 16'h0200;
      wr(8'h08, 32'h8 | (32'h1 << i));
      if (i == 0) c1 <= 16'h0400;
      else c2 <= 16'h0400;
      rs(8'h20, 32'h22);
      cur <= 16'h0000;
      rs(8'h20, 32'h08);
      c1 <= 16'h1000;
      c2 <= 16'h1000;
      cur <= 16'h0200;
      rs(8'h20, 32'h22);
    end
    cur <= 16'h0000;
    wr(8'h08, 32'h11);
    c1 <= 16'h0400;
    rs(8'h20, 32'h08);
    c1 <= 16'h1000;
    pk <= 16'h3000;
    rs(8'h20, 32'h22);
    pk <= 16'h1000;
    wr(8'h08, 32'h4);
    cur <= 16'hFE00;
    rs(8'h20, 32'h08);
    cur <= 16'h0000;
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h10);
    rs(8'h20, 32'h62);
    park <= 1'b1;
    wait_mode(BMPM_SHELF, n);
    chk("entry", 34'(n > 24 && n < 100), 34'h1);
    chk("bus", 34'({busen, run}), 34'h0);
    wr(8'h04, 32'h1);
    park <= 1'b0;
    wait_mode(BMPM_RUN, n);
    chk("wake", 34'(n > 16 && n < 100), 34'h1);
    chk("run", 34'({busen, run}), 34'h3);
    rs(8'h04, 32'h0);
    // Two ticks of charge, then two of discharge, aligned to the sample pulses
    wr(8'h08, 32'h20);
    wr(8'h04, 32'h1);
    gap(n);
    cur <= 16'h0100;
    gap(n);
    cur <= 16'hFF00;
    gap(n);
    cur <= 16'h0000;
    rs(8'h24, 32'h200);
    rs(8'h28, 32'h200);
    wrap_up();
  end
endmodule
